// ==== verilog/drf_refresh_fsm.v ====
// device-side command, refresh, power-down and bank state tracker
// What this block does
// - auto refresh: select,row,column low; cke,we high
// - refresh row from internal counter, address ignored
// - refresh completion leaves all banks idle
// - self refresh: refresh code with cke low
// - self refresh ignores all but cke
// - internal clock gated during self refresh
// - cke low idle gives power-down kind
// - power-down ignores all inputs but cke and the command
// - cke high with nop exits power-down
// - cke fall picks precharge or active power-down
// - decode select and strobes into commands
// - open row accepts read, write, precharge
// - read burst accepts read,write,terminate,precharge
// - write burst accepts read,write,precharge
// - idle bank accepts activate and precharge
`include "drf_defines.vh"
module drf_refresh_fsm
#(
   parameter ROW_W = `DRF_ROW_W  // refresh counter width
)
(
   input  wire             REF_CLK_IN,      // system clock
   input  wire             RST_IN,          // sync reset, active high
   input  wire             CKE_IN,          // clock enable pin
   input  wire             CS_N_IN,         // chip select pin
   input  wire             RAS_N_IN,        // row strobe pin
   input  wire             CAS_N_IN,        // column strobe pin
   input  wire             WE_N_IN,         // write enable pin
   input  wire [1:0]       BA_IN,           // bank address pins
   input  wire             AP_IN,           // precharge-all address bit
   output reg  [7:0]       BANK_STATE_OUT,  // two bits per bank
   output reg              REFRESHING_OUT,  // auto refresh busy
   output reg  [ROW_W-1:0] REF_ROW_OUT,     // internal refresh row
   output reg              SELF_REF_OUT,    // in self refresh
   output reg              CLK_GATE_OUT,    // internal clock off
   output reg              PD_PRE_OUT,      // precharge power-down
   output reg              PD_ACT_OUT,      // active power-down
   output reg              DLL_LOCKED_OUT,  // dll lock time elapsed
   output reg              ILLEGAL_OUT      // sticky illegal command
);
   // timer loads cut to the timer width
   localparam [7:0] TRFC_CYC = `DRF_TRFC_CYC;  // refresh busy clocks
   localparam [7:0] DLL_CYC  = `DRF_DLL_CYC;   // dll lock clocks
   // one-hot top states
   localparam ST_NORM = 5'b00001;
   localparam ST_AREF = 5'b00010;
   localparam ST_SREF = 5'b00100;
   localparam ST_PD   = 5'b01000;
   localparam ST_XSR  = 5'b10000;

   // pin synchronisers, stage one read only by stage two
   reg  [7:0]       sync1_r;         // first stage
   reg  [7:0]       sync2_r;         // second stage
   reg              cke_prev_r;      // cke at previous edge
   reg  [4:0]       state_r;         // top state
   reg  [4:0]       state_nxt;       // its next value
   reg  [7:0]       bank_r;          // per-bank state
   reg  [7:0]       bank_nxt;        // its next value
   reg  [3:0]       bcnt_r [0:3];    // burst clocks left per bank
   reg  [7:0]       tcnt_r;          // refresh / dll timer
   reg  [7:0]       tcnt_nxt;        // its next value
   reg  [ROW_W-1:0] row_r;           // refresh row counter
   reg              ill_nxt;         // illegal this edge
   wire [3:0]       cmd;             // decoded command
   wire             cke;             // synced cke
   wire [1:0]       ba;              // synced bank
   wire             ap;              // synced precharge-all
   wire             all_idle;        // every bank idle
   integer          i;               // bank loop

   assign cke = sync2_r[0];
   assign ba  = sync2_r[6:5];
   assign ap  = sync2_r[7];
   assign all_idle = (bank_r == 8'h00);

   // fetch the state of one bank
   function [1:0] bk_get;
      input [7:0] v;
      input [1:0] b;
      begin
         bk_get = v[b*2 +: 2];
      end
   endfunction

   // two-flop sync of every pin
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         // idle pins: cke high, deselect, strobes high
         sync1_r <= 8'h1F;
         sync2_r <= 8'h1F;
      end
      else
      begin
         sync1_r <= {AP_IN, BA_IN, WE_N_IN, CAS_N_IN, RAS_N_IN, CS_N_IN, CKE_IN};
         sync2_r <= sync1_r;
      end
   end

   drf_cmd_decode u_dec
   (
      .cs_n_in  (sync2_r[1]),
      .ras_n_in (sync2_r[2]),
      .cas_n_in (sync2_r[3]),
      .we_n_in  (sync2_r[4]),
      .cmd_out  (cmd)
   );

   // next state, bank states and legality
   always @*
   begin
      state_nxt = state_r;
      bank_nxt  = bank_r;
      tcnt_nxt  = tcnt_r;
      ill_nxt   = 1'b0;
      // bursts that ran out return to row active
      for (i = 0; i < 4; i = i + 1)
      begin
         if (bank_r[i*2 +: 2] >= `DRF_BK_READ && bcnt_r[i] == 4'h1)
            bank_nxt[i*2 +: 2] = `DRF_BK_ACTIVE;
      end
      case (state_r)
         ST_NORM:
         begin
            if (cke_prev_r && !cke)
            begin
               if (cmd == `DRF_CMD_AREF && all_idle)
                  state_nxt = ST_SREF;
               else if (cmd <= `DRF_CMD_NOP)
                  state_nxt = ST_PD;
               else
                  ill_nxt = 1'b1;
            end
            else if (cmd == `DRF_CMD_AREF || cmd == `DRF_CMD_MRS)
            begin
               if (!all_idle)
                  ill_nxt = 1'b1;
               else if (cmd == `DRF_CMD_AREF)
               begin
                  state_nxt = ST_AREF;
                  tcnt_nxt  = TRFC_CYC;
               end
            end
            else if (cmd > `DRF_CMD_NOP)
            begin
               // check against the addressed bank only
               case (bk_get(bank_r, ba))
                  `DRF_BK_IDLE:
                  begin
                     if (cmd == `DRF_CMD_ACT)
                        bank_nxt[ba*2 +: 2] = `DRF_BK_ACTIVE;
                     else if (cmd == `DRF_CMD_PRE && ap)
                        bank_nxt = 8'h00;
                     else if (cmd != `DRF_CMD_PRE)
                        ill_nxt = 1'b1;
                  end
                  default:
                  begin
                     if (cmd == `DRF_CMD_READ)
                        bank_nxt[ba*2 +: 2] = `DRF_BK_READ;
                     else if (cmd == `DRF_CMD_WRITE)
                        bank_nxt[ba*2 +: 2] = `DRF_BK_WRITE;
                     else if (cmd == `DRF_CMD_PRE)
                     begin
                        if (ap)
                           bank_nxt = 8'h00;
                        else
                           bank_nxt[ba*2 +: 2] = `DRF_BK_IDLE;
                     end
                     else if (cmd == `DRF_CMD_BST &&
                              bk_get(bank_r, ba) == `DRF_BK_READ)
                        bank_nxt[ba*2 +: 2] = `DRF_BK_ACTIVE;
                     else
                        ill_nxt = 1'b1;
                  end
               endcase
            end
         end
         ST_AREF:
         begin
            // address ignored while counting, any command but nop or deselect flagged illegal
            if (cmd > `DRF_CMD_NOP)
               ill_nxt = 1'b1;
            if (tcnt_r == 8'h01)
            begin
               state_nxt = ST_NORM;
               bank_nxt  = 8'h00;
            end
            tcnt_nxt = tcnt_r - 8'h01;
         end
         ST_SREF:
         begin
            // only cke watched
            if (cke)
            begin
               state_nxt = ST_XSR;
               tcnt_nxt  = DLL_CYC;
            end
         end
         ST_PD:
         begin
            // only cke and a nop or deselect command watched
            if (cke && cmd <= `DRF_CMD_NOP)
               state_nxt = ST_NORM;
         end
         ST_XSR:
         begin
            // dll lock wait, executable only after it
            if (tcnt_r == 8'h01)
               state_nxt = ST_NORM;
            if (cmd > `DRF_CMD_NOP)
               ill_nxt = 1'b1;
            tcnt_nxt = tcnt_r - 8'h01;
         end
         default:
            state_nxt = ST_NORM;
      endcase
   end

   // state registers
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         state_r     <= ST_NORM;
         bank_r      <= 8'h00;
         tcnt_r      <= 8'h00;
         row_r       <= {ROW_W{1'b0}};
         cke_prev_r  <= 1'b1;
         ILLEGAL_OUT <= 1'b0;
         for (i = 0; i < 4; i = i + 1)
            bcnt_r[i] <= 4'h0;
      end
      else
      begin
         state_r    <= state_nxt;
         bank_r     <= bank_nxt;
         tcnt_r     <= tcnt_nxt;
         cke_prev_r <= cke;
         // sticky until reset
         if (ill_nxt)
            ILLEGAL_OUT <= 1'b1;
         // internal row advances per auto refresh
         if (state_r == ST_NORM && state_nxt == ST_AREF)
            row_r <= row_r + 1'b1;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (bank_nxt[i*2 +: 2] >= `DRF_BK_READ && bank_nxt != bank_r &&
                bk_get(bank_r, i[1:0]) != bank_nxt[i*2 +: 2])
               bcnt_r[i] <= `DRF_BURST_CLK;
            else if (state_r == ST_NORM && i[1:0] == ba &&
                     (cmd == `DRF_CMD_READ || cmd == `DRF_CMD_WRITE))
               bcnt_r[i] <= `DRF_BURST_CLK;
            else if (bcnt_r[i] != 4'h0)
               bcnt_r[i] <= bcnt_r[i] - 4'h1;
         end
      end
   end

   // registered status outputs
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         BANK_STATE_OUT <= 8'h00;
         REFRESHING_OUT <= 1'b0;
         REF_ROW_OUT    <= {ROW_W{1'b0}};
         SELF_REF_OUT   <= 1'b0;
         CLK_GATE_OUT   <= 1'b0;
         PD_PRE_OUT     <= 1'b0;
         PD_ACT_OUT     <= 1'b0;
         DLL_LOCKED_OUT <= 1'b1;
      end
      else
      begin
         BANK_STATE_OUT <= bank_nxt;
         REFRESHING_OUT <= (state_nxt == ST_AREF);
         REF_ROW_OUT    <= row_r;
         SELF_REF_OUT   <= (state_nxt == ST_SREF);
         CLK_GATE_OUT   <= (state_nxt == ST_SREF);
         PD_PRE_OUT     <= (state_nxt == ST_PD) && (bank_nxt == 8'h00);
         PD_ACT_OUT     <= (state_nxt == ST_PD) && (bank_nxt != 8'h00);
         DLL_LOCKED_OUT <= (state_nxt != ST_XSR) && (state_nxt != ST_SREF);
      end
   end
endmodule // drf_refresh_fsm

// ==== verilog/drf_defines.vh ====
// constants for the ddr refresh and power-down command state block
`ifndef DRF_DEFINES_VH
`define DRF_DEFINES_VH
// command codes after decode
`define DRF_CMD_DESEL   4'h0
`define DRF_CMD_NOP     4'h1
`define DRF_CMD_ACT     4'h2
`define DRF_CMD_READ    4'h3
`define DRF_CMD_WRITE   4'h4
`define DRF_CMD_PRE     4'h5
`define DRF_CMD_BST     4'h6
`define DRF_CMD_AREF    4'h7
`define DRF_CMD_MRS     4'h8
// bank state codes
`define DRF_BK_IDLE     2'h0
`define DRF_BK_ACTIVE   2'h1
`define DRF_BK_READ     2'h2
`define DRF_BK_WRITE    2'h3
// refresh row counter width and precharge-all address bit
`define DRF_ROW_W       12
`define DRF_AP_BIT      8
// burst length in clocks and refresh busy time
`define DRF_BURST_CLK   4'h2
`define DRF_TRFC_NS     80
`define DRF_CLK_NS      20
`define DRF_TRFC_CYC    ((`DRF_TRFC_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
// dll lock count after self refresh exit
`define DRF_DLL_CYC     200
`endif

// ==== verilog/drf_cmd_decode.v ====
// command decoder for chip select and the three strobes
module drf_cmd_decode
(
   input  wire       cs_n_in,   // chip select, active low
   input  wire       ras_n_in,  // row strobe, active low
   input  wire       cas_n_in,  // column strobe, active low
   input  wire       we_n_in,   // write enable, active low
   output reg  [3:0] cmd_out    // decoded command code
);
`include "drf_defines.vh"
   // plain truth-table decode
   always @*
   begin
      if (cs_n_in)
         cmd_out = `DRF_CMD_DESEL;
      else
      begin
         case ({ras_n_in, cas_n_in, we_n_in})
            3'b111:  cmd_out = `DRF_CMD_NOP;
            3'b011:  cmd_out = `DRF_CMD_ACT;
            3'b101:  cmd_out = `DRF_CMD_READ;
            3'b100:  cmd_out = `DRF_CMD_WRITE;
            3'b010:  cmd_out = `DRF_CMD_PRE;
            3'b110:  cmd_out = `DRF_CMD_BST;
            3'b001:  cmd_out = `DRF_CMD_AREF;
            default: cmd_out = `DRF_CMD_MRS;
         endcase
      end
   end
endmodule // drf_cmd_decode

// ==== tb/drf_refresh_monitor.sv ====
// assertion checker for the refresh and power-down command block
module drf_refresh_monitor
#(
   parameter ROW_W = 12  // refresh counter width
)
(
   input logic             REF_CLK_IN,
   input logic             RST_IN,
   input logic             CKE_IN,
   input logic             CS_N_IN,
   input logic             RAS_N_IN,
   input logic             CAS_N_IN,
   input logic             WE_N_IN,
   input logic [1:0]       BA_IN,
   input logic             AP_IN,
   input logic [7:0]       BANK_STATE_OUT,
   input logic             REFRESHING_OUT,
   input logic [ROW_W-1:0] REF_ROW_OUT,
   input logic             SELF_REF_OUT,
   input logic             CLK_GATE_OUT,
   input logic             PD_PRE_OUT,
   input logic             PD_ACT_OUT,
   input logic             DLL_LOCKED_OUT,
   input logic             ILLEGAL_OUT
);
   logic [8:0]       lock_cnt_r;  // cycles spent waiting for dll lock
   wire  [ROW_W-1:0] one_w = 1;   // row step
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);
   // count the dll wait after self refresh exit
   always_ff @(posedge REF_CLK_IN)
      lock_cnt_r <= (RST_IN || DLL_LOCKED_OUT || SELF_REF_OUT) ? 9'h000
                                                              : lock_cnt_r + 9'h001;
   // all banks idle, nothing busy, clock enable was high
   sequence s_quiet;
      $past(CKE_IN) && BANK_STATE_OUT == 8'h00 && !REFRESHING_OUT && !SELF_REF_OUT && DLL_LOCKED_OUT;
   endsequence
   // refresh code on the pins
   sequence s_aref_cmd;
      !CS_N_IN && !RAS_N_IN && !CAS_N_IN && WE_N_IN;
   endsequence
   property p_aref; s_quiet ##0 s_aref_cmd ##0 CKE_IN |-> ##[1:5] REFRESHING_OUT; endproperty
   a_aref: assert property (p_aref) else $error("refresh not started");
   property p_sref; s_quiet ##0 s_aref_cmd ##0 !CKE_IN |-> ##[1:5] SELF_REF_OUT; endproperty
   a_sref: assert property (p_sref) else $error("self refresh not entered");
   property p_rlen; $rose(REFRESHING_OUT) |-> REFRESHING_OUT [*4] ##1 !REFRESHING_OUT; endproperty
   a_rlen: assert property (p_rlen) else $error("refresh busy length wrong");
   property p_idle; $fell(REFRESHING_OUT) |-> BANK_STATE_OUT == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("banks not idle after refresh");
   property p_row; $changed(REF_ROW_OUT) |-> REF_ROW_OUT - $past(REF_ROW_OUT) == one_w; endproperty
   a_row: assert property (p_row) else $error("refresh row step wrong");
   property p_gate; CLK_GATE_OUT == SELF_REF_OUT; endproperty
   a_gate: assert property (p_gate) else $error("clock gate differs from self refresh");
   property p_srhold;
      SELF_REF_OUT && $past(SELF_REF_OUT) |->
         $stable(BANK_STATE_OUT) && $stable(ILLEGAL_OUT) && !DLL_LOCKED_OUT;
   endproperty
   a_srhold: assert property (p_srhold) else $error("state moved in self refresh");
   property p_lock; $rose(DLL_LOCKED_OUT) |-> lock_cnt_r >= 9'h0C6 && lock_cnt_r <= 9'h0CA; endproperty
   a_lock: assert property (p_lock) else $error("dll wait length wrong");
   property p_pdk;
      PD_PRE_OUT || PD_ACT_OUT |-> PD_ACT_OUT != PD_PRE_OUT && PD_ACT_OUT == (BANK_STATE_OUT != 8'h00);
   endproperty
   a_pdk: assert property (p_pdk) else $error("wrong power-down kind");
   property p_pdst;
      (PD_PRE_OUT || PD_ACT_OUT) && $past(PD_PRE_OUT || PD_ACT_OUT) |->
         $stable(BANK_STATE_OUT) && $stable(ILLEGAL_OUT);
   endproperty
   a_pdst: assert property (p_pdst) else $error("state moved in power-down");
endmodule  // drf_refresh_monitor
bind drf_refresh_fsm drf_refresh_monitor #(.ROW_W(ROW_W)) mon_u (.REF_CLK_IN, .RST_IN, .CKE_IN,
   .CS_N_IN, .RAS_N_IN, .CAS_N_IN, .WE_N_IN, .BA_IN, .AP_IN, .BANK_STATE_OUT, .REFRESHING_OUT,
   .REF_ROW_OUT, .SELF_REF_OUT, .CLK_GATE_OUT, .PD_PRE_OUT, .PD_ACT_OUT, .DLL_LOCKED_OUT,
   .ILLEGAL_OUT);

// ==== tb/drf_ctl_model.sv ====
// controller-side model that drives command pins
`include "drf_defines.vh"
module drf_ctl_model
(
   input  logic       clk_in,    // system clock
   output logic       cke_out,   // clock enable
   output logic       cs_n_out,  // chip select, active low
   output logic       ras_n_out, // row strobe, active low
   output logic       cas_n_out, // column strobe, active low
   output logic       we_n_out,  // write enable, active low
   output logic [1:0] ba_out,    // bank address
   output logic       ap_out     // precharge-all bit
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus: clock enabled, deselected
   initial
   begin
      {cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out} = 5'h1F;
      ba_out = 2'h0;
      ap_out = 1'b0;
   end
   // one command, then g cycles of nop, or 5 after an auto refresh with g of 4 or less, with the same clock enable
   task automatic send(input logic [3:0] c, input logic k, input logic [1:0] b,
                       input logic a, input int g);
      logic [2:0] rcw;  // row, column, write strobes
      int         n;    // nop cycles after the command
      case (c)
         `DRF_CMD_ACT:   rcw = 3'h3;
         `DRF_CMD_READ:  rcw = 3'h5;
         `DRF_CMD_WRITE: rcw = 3'h4;
         `DRF_CMD_PRE:   rcw = 3'h2;
         `DRF_CMD_BST:   rcw = 3'h6;
         `DRF_CMD_AREF:  rcw = 3'h1;
         `DRF_CMD_MRS:   rcw = 3'h0;
         default:        rcw = 3'h7;
      endcase
      // refresh busy time always honoured
      n = (c == `DRF_CMD_AREF && k && g <= `DRF_TRFC_CYC) ? `DRF_TRFC_CYC + 1 : g;
      @(posedge clk_in);
      #1;
      {cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out} = {k, c == `DRF_CMD_DESEL, rcw};
      ba_out = b;
      ap_out = a;
      // only nop between commands, address lines wandering
      repeat (n)
      begin
         @(posedge clk_in);
         #1;
         {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'h7;
         ba_out = ~ba_out;
         ap_out = ~ap_out;
      end
   endtask
endmodule  // drf_ctl_model

// ==== tb/tb.sv ====
// self-checking bench for the refresh and power-down command block
`include "drf_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;       // 50 MHz clock
   logic        rst     = 1'b1;       // sync reset
   logic        cke, cs_n, ras_n, cas_n, we_n, ap;  // pins from the model
   logic [1:0]  ba;                   // bank pins from the model
   logic [7:0]  bank_state;           // per-bank state
   logic [11:0] ref_row;              // refresh row
   logic        refr, sr, gate, pd_pre, pd_act, dll, ill;  // status
   logic [12:0] exp_q[$];             // expected status changes
   logic [12:0] e_v    = 13'h0000;    // running expectation
   logic [12:0] last_v = 13'h0000;    // last status seen
   logic [1:0]  b;                    // bank under test
   int          errors = 0;
   int          checks_done = 0;
   int          cyc = 0;
   wire  [12:0] obs = {bank_state, refr, sr, pd_pre, pd_act, ill};
   always #10 ref_clk = ~ref_clk;
   drf_refresh_fsm dut_u (.REF_CLK_IN(ref_clk), .RST_IN(rst), .CKE_IN(cke), .CS_N_IN(cs_n),
      .RAS_N_IN(ras_n), .CAS_N_IN(cas_n), .WE_N_IN(we_n), .BA_IN(ba), .AP_IN(ap),
      .BANK_STATE_OUT(bank_state), .REFRESHING_OUT(refr), .REF_ROW_OUT(ref_row),
      .SELF_REF_OUT(sr), .CLK_GATE_OUT(gate), .PD_PRE_OUT(pd_pre), .PD_ACT_OUT(pd_act),
      .DLL_LOCKED_OUT(dll), .ILLEGAL_OUT(ill));
   drf_ctl_model pm_u (.clk_in(ref_clk), .cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n),
      .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba), .ap_out(ap));
   task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // note a bank state change
   task automatic note(input logic [1:0] bk, input logic [1:0] st);
      e_v[5 + 2 * bk +: 2] = st;
      exp_q.push_back(e_v);
   endtask
   // note a flag change
   task automatic flag(input int pos, input logic v);
      e_v[pos] = v;
      exp_q.push_back(e_v);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // take the oldest note at each status change
   always @(posedge ref_clk)
   begin
      #2;
      if (!rst && obs !== last_v)
      begin
         last_v = obs;
         check("status", obs, exp_q.size() > 0 ? exp_q.pop_front() : ~obs);
      end
   end
   // cut a hang short
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errors++;
         stop_test();
      end
   end
   initial
   begin
      void'($urandom(4864));
      repeat (6) @(posedge ref_clk);
      #1 rst = 1'b0;
      check("reset", obs, 13'h0000);
      check("dll", {12'h000, dll}, 13'h0001);
      b = 2'($urandom % 4);
      // expectations are queued before the command that causes them
      note(b, 2'h1);
      pm_u.send(`DRF_CMD_ACT, 1'b1, b, 1'b0, 5);
      note(b, 2'h2);
      note(b, 2'h1);
      pm_u.send(`DRF_CMD_READ, 1'b1, b, 1'b0, 5);
      note(b, 2'h2);
      note(b, 2'h1);
      pm_u.send(`DRF_CMD_READ, 1'b1, b, 1'b0, 0);
      pm_u.send(`DRF_CMD_BST, 1'b1, b, 1'b0, 5);
      note(b, 2'h3);
      note(b, 2'h2);
      note(b, 2'h1);
      pm_u.send(`DRF_CMD_WRITE, 1'b1, b, 1'b0, 0);
      pm_u.send(`DRF_CMD_READ, 1'b1, b, 1'b0, 5);
      note(2'(b + 1), 2'h1);
      pm_u.send(`DRF_CMD_ACT, 1'b1, 2'(b + 1), 1'b0, 5);
      e_v[12:5] = 8'h00;
      exp_q.push_back(e_v);
      pm_u.send(`DRF_CMD_PRE, 1'b1, b, 1'b1, 5);
      $display("test banks done");
      flag(4, 1'b1);
      flag(4, 1'b0);
      pm_u.send(`DRF_CMD_AREF, 1'b1, 2'($urandom), 1'($urandom), 8);
      check("row", {1'b0, ref_row}, 13'h0001);
      note(b, 2'h1);
      pm_u.send(`DRF_CMD_ACT, 1'b1, b, 1'b0, 4);
      flag(1, 1'b1);
      pm_u.send(`DRF_CMD_NOP, 1'b0, b, 1'b0, 4);
      flag(1, 1'b0);
      pm_u.send(`DRF_CMD_NOP, 1'b1, b, 1'b0, 4);
      note(b, 2'h0);
      pm_u.send(`DRF_CMD_PRE, 1'b1, b, 1'b0, 4);
      flag(2, 1'b1);
      pm_u.send(`DRF_CMD_DESEL, 1'b0, b, 1'b0, 4);
      flag(2, 1'b0);
      pm_u.send(`DRF_CMD_DESEL, 1'b1, b, 1'b0, 4);
      $display("test refresh and power-down done");
      flag(3, 1'b1);
      pm_u.send(`DRF_CMD_AREF, 1'b0, b, 1'b0, 2);
      repeat (10) pm_u.send(4'($urandom % 9), 1'b0, 2'($urandom), 1'($urandom), 0);
      check("gate", {12'h000, gate}, 13'h0001);
      check("dll", {12'h000, dll}, 13'h0000);
      flag(3, 1'b0);
      pm_u.send(`DRF_CMD_NOP, 1'b1, b, 1'b0, 3);
      check("gate", {12'h000, gate}, 13'h0000);
      check("dll", {12'h000, dll}, 13'h0000);
      pm_u.send(`DRF_CMD_NOP, 1'b1, b, 1'b0, 205);
      check("dll", {12'h000, dll}, 13'h0001);
      flag(4, 1'b1);
      flag(4, 1'b0);
      pm_u.send(`DRF_CMD_AREF, 1'b1, b, 1'b0, 8);
      check("row", {1'b0, ref_row}, 13'h0002);
      $display("test self refresh done");
      flag(0, 1'b1);
      pm_u.send(`DRF_CMD_READ, 1'b1, b, 1'b0, 10);
      check("pending", 13'(exp_q.size()), 13'h0000);
      $display("test refusal done");
      // nothing further is sent after an illegal command
      stop_test();
   end
endmodule  // tb
